// ===== pkg/brt_regs.svh
// Purpose: Constants for the block register move sequencer
// Assumes: 16-bit words, byte addresses, 16 general registers
// Notes: Cycle budgets are in processor cycles
`ifndef BRT_REGS_SVH
`define BRT_REGS_SVH
`define BRT_OPC_HI 6'h1C
`define BRT_DIR_LOAD 4'h1
`define BRT_DIR_STORE 4'h9
`define BRT_MODE_IR 2'h0
`define BRT_MODE_DX 2'h1
`define BRT_FORM_IR 2'h0
`define BRT_FORM_DA 2'h1
`define BRT_FORM_X 2'h2
`define BRT_ADDR_STEP 24'h00_0002
`define BRT_CYC_PER_REG 7'h03
`define BRT_CYC_IR 7'h0B
`define BRT_CYC_DA_NS 7'h0E
`define BRT_CYC_DA_SS 7'h0F
`define BRT_CYC_DA_SL 7'h11
`define BRT_CYC_X 7'h0F
`define BRT_CYC_X_SL 7'h12
`endif

// ===== pkg/brt_pkg.sv
// Purpose: Types for the block register move sequencer
// Assumes: Used with brt_regs.svh
// Notes: Nothing is imported; use brt_pkg::name
package brt_pkg;
  // Decoded instruction
  typedef struct packed {
    logic valid;
    logic store;
    logic [1:0] mode;
    logic [3:0] ptr;
    logic [3:0] reg0;
    logic [4:0] count;
  } brt_dec_t;
  // Memory request
  typedef struct packed {
    logic req;
    logic write;
    logic [23:0] addr;
    logic [15:0] wdata;
  } brt_mreq_t;
  // Register file write
  typedef struct packed {
    logic we;
    logic [3:0] idx;
    logic [15:0] data;
  } brt_rwr_t;
  typedef enum logic [1:0] {
    BRT_IDLE = 2'b00,
    BRT_XFER = 2'b01,
    BRT_WAIT = 2'b10,
    BRT_PAD = 2'b11
  } brt_state_t;
endpackage

// ===== core/brt_decode.sv
// Purpose: Decodes the two instruction words of a block register move
// Assumes: Words presented together; combinational
// Notes: Rejects opcodes and pointer fields that are not legal
`timescale 1ns/1ps
`default_nettype none
`include "brt_regs.svh"
module brt_decode (
  input wire logic [15:0] word0_in, // First instruction word
  input wire logic [15:0] word1_in, // Second instruction word
  output var brt_pkg::brt_dec_t dec_out // Decoded fields
);
  // Field extraction and legality
  always_comb begin
    dec_out.mode = word0_in[15:14];
    dec_out.ptr = word0_in[7:4];
    dec_out.store = (word0_in[3:0] == `BRT_DIR_STORE);
    dec_out.reg0 = word1_in[11:8];
    dec_out.count = {1'b0, word1_in[3:0]} + 5'h01;
    dec_out.valid = (word0_in[13:8] == `BRT_OPC_HI) && (word0_in[15] == 1'b0)
      && ((word0_in[3:0] == `BRT_DIR_LOAD) || (word0_in[3:0] == `BRT_DIR_STORE))
      && !((word0_in[15:14] == `BRT_MODE_IR) && (word0_in[7:4] == 4'h0));
  end
endmodule
`default_nettype wire

// ===== core/brt_seq.sv
// Purpose: Sequences a block register move between registers and memory
// Assumes: Core supplies register values and the pointer/index contents
// Notes: Flags are never touched; no register other than targets written
`timescale 1ns/1ps
`default_nettype none
`include "brt_regs.svh"
module brt_seq (
  input wire logic clk_in, // 200 MHz clock
  input wire logic reset_in, // Async reset, active high
  input wire logic start_in, // Pulse: begin instruction
  input wire logic [15:0] word0_in, // First instruction word
  input wire logic [15:0] word1_in, // Second instruction word
  input wire logic [23:0] ext_in, // Address extension word(s)
  input wire logic seg_in, // Segmented mode
  input wire logic long_seg_in, // Long segment address form
  input wire logic [15:0] ptr_lo_in, // Pointer/index register
  input wire logic [15:0] ptr_hi_in, // Pair high word (segment)
  input wire logic [15:0] rdata_reg_in, // Value of register rd_idx_out
  input wire logic mem_done_in, // Memory transaction complete
  input wire logic [15:0] mem_rdata_in, // Memory read data
  output logic [3:0] rd_idx_out, // Register being read
  output var brt_pkg::brt_mreq_t mreq_out, // Memory request
  output var brt_pkg::brt_rwr_t rwr_out, // Register write
  output logic busy_out, // Instruction running
  output logic done_out, // Pulse: instruction complete
  output logic illegal_out // Pulse: undecodable instruction
);
  brt_pkg::brt_dec_t dec;
  brt_pkg::brt_state_t state_q, state_d;
  logic [23:0] addr_q, addr_d;
  logic [3:0] idx_q, idx_d;
  logic [4:0] left_q, left_d;
  logic store_q, store_d;
  logic [6:0] cyc_q, cyc_d;
  logic [6:0] budget_q, budget_d;
  brt_pkg::brt_mreq_t mreq_q, mreq_d;
  brt_pkg::brt_rwr_t rwr_q, rwr_d;
  logic done_q, done_d, ill_q, ill_d;
  logic busy_q, busy_d;

  // ----------------------------------------
  // Instruction field decode
  // ----------------------------------------
  brt_decode u_dec (
    .word0_in(word0_in),
    .word1_in(word1_in),
    .dec_out(dec)
  );

  // ----------------------------------------
  // Operand address forms
  // ----------------------------------------
  // Indirect, direct or indexed, shared by budget and address
  function automatic logic [1:0] addr_form(input logic [1:0] mode, input logic [3:0] ptr);
    if (mode == `BRT_MODE_IR) begin
      addr_form = `BRT_FORM_IR;
    end else if (ptr == 4'h0) begin
      addr_form = `BRT_FORM_DA;
    end else begin
      addr_form = `BRT_FORM_X;
    end
  endfunction

  // Fixed overhead by addressing form
  function automatic logic [6:0] base_cycles(input logic [1:0] mode, input logic [3:0] ptr,
                                             input logic seg, input logic lng);
    if (addr_form(mode, ptr) == `BRT_FORM_IR) begin
      base_cycles = `BRT_CYC_IR;
    end else if (addr_form(mode, ptr) == `BRT_FORM_DA) begin
      base_cycles = !seg ? `BRT_CYC_DA_NS : (lng ? `BRT_CYC_DA_SL : `BRT_CYC_DA_SS);
    end else begin
      base_cycles = (seg && lng) ? `BRT_CYC_X_SL : `BRT_CYC_X;
    end
  endfunction

  // Effective address, formed once from a copy of the operand
  function automatic logic [23:0] eff_addr(input logic [1:0] mode, input logic [3:0] ptr,
                                          input logic seg, input logic [15:0] lo,
                                          input logic [15:0] hi, input logic [23:0] ext);
    if (addr_form(mode, ptr) == `BRT_FORM_IR) begin
      eff_addr = seg ? {hi[14:8], 1'b0, lo} : {8'h00, lo};
    end else if (addr_form(mode, ptr) == `BRT_FORM_DA) begin
      eff_addr = ext;
    end else begin
      eff_addr = {ext[23:16], ext[15:0] + lo};
    end
  endfunction

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    idx_d = idx_q;
    left_d = left_q;
    store_d = store_q;
    cyc_d = cyc_q;
    budget_d = budget_q;
    mreq_d = mreq_q;
    rwr_d = '0;
    done_d = 1'b0;
    ill_d = 1'b0;
    if (state_q != brt_pkg::BRT_IDLE) begin
      cyc_d = cyc_q + 7'h01;
    end
    case (state_q)
      // Take a start and latch a private copy of the operands
      brt_pkg::BRT_IDLE: begin
        if (start_in) begin
          if (dec.valid) begin
            addr_d = eff_addr(dec.mode, dec.ptr, seg_in, ptr_lo_in, ptr_hi_in, ext_in);
            idx_d = dec.reg0;
            left_d = dec.count;
            store_d = dec.store;
            cyc_d = 7'h01;
            budget_d = base_cycles(dec.mode, dec.ptr, seg_in, long_seg_in);
            state_d = brt_pkg::BRT_XFER;
          end else begin
            ill_d = 1'b1;
          end
        end
      end
      // Issue one word; store data is taken the cycle before req rises
      brt_pkg::BRT_XFER: begin
        mreq_d.req = 1'b1;
        mreq_d.write = store_q;
        mreq_d.addr = addr_q;
        mreq_d.wdata = rdata_reg_in;
        state_d = brt_pkg::BRT_WAIT;
      end
      // Hold the request until the memory finishes the word
      brt_pkg::BRT_WAIT: begin
        if (mem_done_in) begin
          mreq_d.req = 1'b0;
          if (!store_q) begin
            rwr_d.we = 1'b1;
            rwr_d.idx = idx_q;
            rwr_d.data = mem_rdata_in;
          end
          idx_d = idx_q + 4'h1;
          addr_d = addr_q + `BRT_ADDR_STEP;
          left_d = left_q - 5'h01;
          budget_d = budget_q + `BRT_CYC_PER_REG;
          state_d = (left_q == 5'h01) ? brt_pkg::BRT_PAD : brt_pkg::BRT_XFER;
        end
      end
      // Spend the rest of the cycle budget
      // Slow memory can overrun it: the budget is a minimum, not a limit
      brt_pkg::BRT_PAD: begin
        if (cyc_q >= budget_q - 7'h01) begin
          done_d = 1'b1;
          state_d = brt_pkg::BRT_IDLE;
        end
      end
      default: state_d = brt_pkg::BRT_IDLE;
    endcase
    // Busy follows the next state so the output is a flop, not a decode
    busy_d = (state_d != brt_pkg::BRT_IDLE);
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= brt_pkg::BRT_IDLE;
      addr_q <= 24'h00_0000;
      idx_q <= 4'h0;
      left_q <= 5'h00;
      store_q <= 1'b0;
      cyc_q <= 7'h00;
      budget_q <= 7'h00;
      mreq_q <= '0;
      rwr_q <= '0;
      done_q <= 1'b0;
      ill_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      idx_q <= idx_d;
      left_q <= left_d;
      store_q <= store_d;
      cyc_q <= cyc_d;
      budget_q <= budget_d;
      mreq_q <= mreq_d;
      rwr_q <= rwr_d;
      done_q <= done_d;
      ill_q <= ill_d;
      busy_q <= busy_d;
    end
  end

  // ----------------------------------------
  // Outputs straight from flops
  // ----------------------------------------
  assign rd_idx_out = idx_q;
  assign mreq_out = mreq_q;
  assign rwr_out = rwr_q;
  assign busy_out = busy_q;
  assign done_out = done_q;
  assign illegal_out = ill_q;
endmodule
`default_nettype wire

// ===== dv/brt_chk.sv
// Purpose: Port checks on the block move sequencer
// Assumes: Bound to brt_seq
// Notes: Memory may answer late
`timescale 1ns/1ps
`default_nettype none
module brt_chk (
  input wire logic clk_in, // Clock
  input wire logic reset_in, // Reset
  input wire logic start_in, // Start
  input wire logic busy_out, // Busy
  input wire logic illegal_out, // Refused
  input wire logic done_out, // Done
  input wire logic [3:0] rd_idx_out, // Reg index
  input wire logic mem_done_in, // Bus done
  input wire logic [15:0] mem_rdata_in, // Read data
  input wire brt_pkg::brt_mreq_t mreq_out, // Request
  input wire brt_pkg::brt_rwr_t rwr_out // Reg write
);
  // --------
  // Checks
  // --------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  property p_st; start_in && !busy_out |=> busy_out || illegal_out; endproperty
  a_st: assert property (p_st) else $error("start not taken");
  property p_rq; start_in && !busy_out ##1 busy_out |=> mreq_out.req; endproperty
  a_rq: assert property (p_rq) else $error("no request");
  property p_hd; mreq_out.req && !mem_done_in |=> mreq_out.req && $stable(mreq_out.addr);
  endproperty
  a_hd: assert property (p_hd) else $error("request dropped");
  property p_dr; mreq_out.req && mem_done_in |=> !mreq_out.req; endproperty
  a_dr: assert property (p_dr) else $error("request held");
  property p_ad; mreq_out.req && mem_done_in |-> ##2
    (!mreq_out.req || mreq_out.addr == $past(mreq_out.addr, 2) + 24'h00_0002); endproperty
  a_ad: assert property (p_ad) else $error("bad address step");
  property p_wd; mreq_out.req && mem_done_in && !mreq_out.write |=>
    rwr_out.we && rwr_out.data == $past(mem_rdata_in); endproperty
  a_wd: assert property (p_wd) else $error("bad load write");
  property p_we; rwr_out.we |-> $past(mreq_out.req && mem_done_in && !mreq_out.write);
  endproperty
  a_we: assert property (p_we) else $error("stray write");
  property p_il; illegal_out |-> !busy_out && !mreq_out.req; endproperty
  a_il: assert property (p_il) else $error("refused but busy");
  property p_ix; mreq_out.req && mem_done_in |=> rd_idx_out == $past(rd_idx_out) + 4'h1;
  endproperty
  a_ix: assert property (p_ix) else $error("register order broken");
  property p_dn; done_out |-> !busy_out && !mreq_out.req; endproperty
  a_dn: assert property (p_dn) else $error("done while busy");
endmodule
bind brt_seq brt_chk i_chk (.clk_in, .reset_in, .start_in, .busy_out, .illegal_out,
  .done_out, .rd_idx_out, .mem_done_in, .mem_rdata_in, .mreq_out, .rwr_out);
`default_nettype wire

// ===== dv/brt_mem_model.sv
// Purpose: Word memory behind the processor bus
// Assumes: 256 words, byte address
// Notes: Slow mode adds three wait cycles
`timescale 1ns/1ps
`default_nettype none
module brt_mem_model (
  input wire logic clk_in, // Clock
  input wire logic slow_in, // Wait cycles on
  input wire brt_pkg::brt_mreq_t mreq_in, // Request
  output logic done_out, // Transaction done
  output logic [15:0] rdata_out // Read data
);
  logic [15:0] mem [256];
  logic [15:0] last_q;
  logic [1:0] wait_q;
  wire [7:0] idx = mreq_in.addr[8:1];
  initial begin
    wait_q = 2'h0;
    last_q = 16'h0000;
    for (int i = 0; i < 256; i++) mem[i] = {8'(i), 8'(~i)};
  end
  // One word per request, answered after the wait
  assign done_out = mreq_in.req && (wait_q == (slow_in ? 2'h3 : 2'h0));
  // Released data line shows the inverse of the last word
  assign rdata_out = done_out ? mem[idx] : ~last_q;
  always @(posedge clk_in) begin
    wait_q <= (done_out || !mreq_in.req) ? 2'h0 : wait_q + 2'h1;
    if (done_out) last_q <= mreq_in.write ? mreq_in.wdata : mem[idx];
    if (done_out && mreq_in.write) mem[idx] <= mreq_in.wdata;
  end
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
// Purpose: Self-checking bench for the block move sequencer
// Assumes: Prompt or slow memory model
// Notes: Random loads and stores plus corner cases
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_in, reset_in, start_in, seg, lng, slow, done, busy, ill, mdone;
  logic [15:0] w0, w1, plo, phi, mrd;
  logic [23:0] ext;
  logic [15:0] regs [16];
  logic [3:0] rd_idx;
  logic [31:0] x;
  brt_pkg::brt_mreq_t mreq;
  brt_pkg::brt_rwr_t rwr;
  int fail_count, cmp_count, seed;
  int cb [5] = '{15, 15, 18, 15, 14};
  brt_seq i_dut (.clk_in(clk_in), .reset_in(reset_in), .start_in(start_in), .word0_in(w0),
    .word1_in(w1), .ext_in(ext), .seg_in(seg), .long_seg_in(lng), .ptr_lo_in(plo),
    .ptr_hi_in(phi), .rdata_reg_in(regs[rd_idx]), .mem_done_in(mdone), .mem_rdata_in(mrd),
    .rd_idx_out(rd_idx), .mreq_out(mreq), .rwr_out(rwr), .busy_out(busy), .done_out(done),
    .illegal_out(ill));
  brt_mem_model i_mem (.clk_in(clk_in), .slow_in(slow), .mreq_in(mreq), .done_out(mdone),
    .rdata_out(mrd));
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    if (fail_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // First word address for each operand form
  function automatic logic [23:0] first_addr(input logic [15:0] a, input logic [15:0] lo);
    if (a[15:14] == 2'b00) first_addr = seg ? {phi[14:8], 1'b0, lo} : {8'h00, lo};
    else if (a[7:4] == 4'h0) first_addr = ext;
    else first_addr = {ext[23:16], ext[15:0] + lo};
  endfunction
  // One instruction; ai is the first word index, base 0 means refused
  task automatic run(input logic [15:0] a, input logic [15:0] b, input int ai, input int base);
    int k, n, w, v;
    logic [23:0] e;
    n = int'(b[3:0]) + 1;
    w = 0;
    v = 0;
    k = 0;
    e = first_addr(a, plo);
    @(negedge clk_in);
    w0 = a;
    w1 = b;
    start_in = 1'b1;
    @(negedge clk_in);
    start_in = 1'b0;
    plo = 16'($random(seed));
    while (done !== 1'b1 && ill !== 1'b1 && k < 300) begin
      if (mreq.req === 1'b1 && mdone === 1'b1) begin
        chk(mreq.addr, e + 24'(2 * w));
        w++;
      end
      if (rwr.we === 1'b1) begin
        chk(rwr.idx, 4'(b[11:8] + v));
        if (ai >= 0) chk(rwr.data, i_mem.mem[8'(ai + v)]);
        v++;
      end
      @(negedge clk_in);
      k++;
    end
    if (k >= 300) begin
      fail_count++;
      complete_run();
    end
    chk(ill, base == 0);
    if (base == 0) chk(w, 0);
    else begin
      chk(w, n);
      // Done shows after edge budget-1, so it is sampled at the budget-th edge
      if (!slow) chk(k, base + 3 * n - 1);
      for (int i = 0; i < n && a[3] && ai >= 0; i++)
        chk(i_mem.mem[8'(ai + i)], regs[4'(b[11:8] + i)]);
    end
  endtask
  initial begin
    seed = 32'h036e_0a54;
    {start_in, seg, lng, slow, w0, w1, ext, phi, plo} = '0;
    fail_count = 0;
    cmp_count = 0;
    reset_in = 1'b1;
    foreach (regs[i]) regs[i] = 16'($random(seed));
    repeat (10) @(negedge clk_in);
    reset_in = 1'b0;
    // Random indirect moves, wrap and pair pointer included
    repeat (40) begin
      x = $random(seed);
      {seg, slow} = x[5:4];
      plo = x[31:16];
      phi = 16'($random(seed));
      run({8'h1c, x[3:2], 2'h2, x[0] ? 4'h9 : 4'h1}, {4'h0, x[11:8], 4'h0, x[15:12]},
        int'(plo[8:1]), 11);
    end
    plo = 16'h01fe;
    run(16'h1c61, 16'h0f0f, 255, 11);
    slow = 1'b0;
    // Indexed budgets in all three forms, direct budget in non-segmented form only
    for (int i = 0; i < 5; i++) begin
      seg = (i == 1 || i == 2);
      lng = (i == 2);
      ext = 24'($random(seed));
      run(i == 3 ? 16'h5c39 : (i == 4 ? 16'h5c01 : 16'h5c31), 16'h0702, -1, cb[i]);
    end
    // Reset in mid-instruction clears busy, request, done and register write
    @(negedge clk_in);
    w0 = 16'h1c61;
    w1 = 16'h0f0f;
    start_in = 1'b1;
    @(negedge clk_in);
    start_in = 1'b0;
    repeat (5) @(negedge clk_in);
    reset_in = 1'b1;
    @(negedge clk_in);
    chk({busy, mreq.req, done, rwr.we}, 4'h0);
    reset_in = 1'b0;
    // Refused words
    run(16'h1c01, 16'h0000, -1, 0);
    run(16'h1d61, 16'h0000, -1, 0);
    run(16'h1c62, 16'h0000, -1, 0);
    complete_run();
  end
endmodule
`default_nettype wire
